//--- core/rsa_top.sv
// Serial RTC register access: FIFO and top level
//
// Summary of operation
// - Respond only while chip select is low
// - Bytes travel most significant bit first
// - First bit taken on first rising clock
// - Sample on rising, shift out on falling
// - One serial clock per bit
// - Everything moves in whole bytes
// - Address bit six is ignored
// - Address advances after each data byte
// - Clock, control, alarm, then user RAM; the code puts plain user RAM right after the clock bytes
// - Clock bytes in BCD, 24-hour
// - Month lengths and leap years handled
// - Time base from 32768 Hz oscillator
// - Power fail aborts and clears address
// - Inputs ignored while supply is bad
// - Protection lasts through recovery time
// - Select falling starts, rising ends
// - Twelve control bytes for alarm functions; the code has no alarms, those bytes are plain RAM
// - First bit write flag, then address
// - Burst address wraps top to zero
// - Clock bytes frozen while addressed
// - Data output released while deselected
`include "rsa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rsa_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = `RSA_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } rsa_fifo_s_t;
    rsa_fifo_s_t q, n;
    logic push, pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("rsa_fifo: depth must be a power of two");
    end

    always_comb begin
        n = q;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (push) begin
            n.mem[q.wp] = in_data_i;
            n.wp = q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = q.rp + 1'b1;
        end
        n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready_o = q.cnt != (AW + 1)'(DEPTH);
    assign out_valid_o = q.cnt != '0;
    assign out_data_o = q.mem[q.rp];
endmodule

module rsa_top #(
    parameter int REC_US = `RSA_REC_US
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Serial bus pins
    input wire logic cs_b_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // Oscillator and supply
    input wire logic osc_32k_i,
    input wire logic power_ok_i,
    output logic wr_protect_o
);
    import rsa_pkg::*;
    localparam int REC_CYC = REC_US * (`RSA_CLK_HZ / `RSA_HZ_PER_MHZ);

    if (REC_CYC < 1) begin : g_chk
        $error("rsa_top: recovery time too short");
    end

    rsa_top_s_t q, n;
    logic [4:0] nf, rise, fall;
    logic cs_fall, shift_en, cmd_done, byte_done, tick, frozen, drain;
    logic [16:0] acc_sum;
    logic r;
    logic f_ready, f_valid;
    logic [13:0] f_data;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Leap rule holds for years 2000 to 2099 only
    function automatic logic [7:0] last_date(input logic [7:0] mo,
                                             input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                        || yr[3:0] == 4'h8);
        case (mo[4:0])
            `RSA_FEB: last_date = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
            default: last_date = 8'h31;
        endcase
    endfunction

    rsa_fifo #(
        .WIDTH(14),
        .DEPTH(`RSA_FIFO_DEPTH)
    ) u_wfifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(q.pend),
        .in_ready_o(f_ready),
        .in_data_i(q.pdat),
        .out_valid_o(f_valid),
        .out_ready_i(!tick),
        .out_data_o(f_data)
    );

    always_comb begin
        n = q;
        // ************************************************
        // Pin synchronisers, change taken once s2 and s3 agree
        // ************************************************
        n.s1 = {power_ok_i, osc_32k_i, sdi_i, sck_i, cs_b_i};
        n.s2 = q.s1;
        n.s3 = q.s2;
        nf = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        n.f = nf;
        rise = nf & ~q.f;
        fall = ~nf & q.f;
        // ************************************************
        // Supply watch and write protection
        // ************************************************
        if (!nf[`RSA_I_POK]) begin
            n.rec = 32'(REC_CYC);
        end else if (q.rec != '0) begin
            n.rec = q.rec - 32'h1;
        end
        n.wp = !nf[`RSA_I_POK] || n.rec != '0;
        // ************************************************
        // Time base, exact 100 Hz average from 32768 Hz
        // ************************************************
        acc_sum = {1'b0, q.acc} + 17'(`RSA_HUND_HZ);
        tick = 1'b0;
        if (rise[`RSA_I_OSC]) begin
            tick = acc_sum >= 17'(`RSA_OSC_HZ);
            n.acc = tick ? 16'(acc_sum - 17'(`RSA_OSC_HZ)) : acc_sum[15:0];
        end
        // ************************************************
        // BCD calendar, 24-hour form
        // ************************************************
        r = tick;
        for (int i = `RSA_A_HUND; i <= `RSA_A_MIN; i++) begin
            if (r) begin
                r = q.cnt[i] == (i == `RSA_A_HUND ? `RSA_MAX_99 : `RSA_MAX_59);
                n.cnt[i] = r ? 8'h00 : bcd_inc(q.cnt[i]);
            end
        end
        if (r) begin
            r = q.cnt[`RSA_A_HOUR][5:0] == `RSA_MAX_HR;
            n.cnt[`RSA_A_HOUR][5:0] = r ? 6'h00
                : 6'(bcd_inc({2'b00, q.cnt[`RSA_A_HOUR][5:0]}));
        end
        if (r) begin
            n.cnt[`RSA_A_DAY][2:0] = q.cnt[`RSA_A_DAY][2:0] == `RSA_MAX_DAY
                ? 3'h1 : q.cnt[`RSA_A_DAY][2:0] + 3'h1;
            r = q.cnt[`RSA_A_DATE] == last_date(q.cnt[`RSA_A_MON],
                                                q.cnt[`RSA_A_YEAR]);
            n.cnt[`RSA_A_DATE] = r ? `RSA_FIRST
                : bcd_inc(q.cnt[`RSA_A_DATE]);
        end
        if (r) begin
            r = q.cnt[`RSA_A_MON][4:0] == `RSA_MAX_MON;
            n.cnt[`RSA_A_MON] = r ? `RSA_FIRST : bcd_inc(q.cnt[`RSA_A_MON]);
        end
        if (r) begin
            n.cnt[`RSA_A_YEAR] = q.cnt[`RSA_A_YEAR] == `RSA_MAX_99
                ? 8'h00 : bcd_inc(q.cnt[`RSA_A_YEAR]);
        end
        // ************************************************
        // Serial engine
        // ************************************************
        cs_fall = 1'b0;
        shift_en = 1'b0;
        cmd_done = 1'b0;
        byte_done = 1'b0;
        if (f_ready) begin
            n.pend = 1'b0;
        end
        if (n.wp || nf[`RSA_I_CS]) begin
            n.st = RSA_IDLE;
            n.oe = 1'b0;
            n.bits = 3'h0;
            if (n.wp) begin
                n.addr = 6'h00;
                n.pend = 1'b0;
            end
        end else if (q.st == RSA_IDLE) begin
            if (fall[`RSA_I_CS]) begin
                cs_fall = 1'b1;
                n.st = RSA_CMD;
            end
        end else if (rise[`RSA_I_SCK]) begin
            shift_en = 1'b1;
            n.sh = {q.sh[6:0], nf[`RSA_I_SDI]};
            n.bits = q.bits + 3'h1;
            if (q.bits == `RSA_LAST_BIT) begin
                if (q.st == RSA_CMD) begin
                    cmd_done = 1'b1;
                    n.wr = n.sh[`RSA_WR_BIT];
                    n.addr = n.sh[5:0];
                    n.st = RSA_DATA;
                    n.ob = q.mem[n.sh[5:0]];
                end else begin
                    byte_done = 1'b1;
                    if (q.wr) begin
                        n.pend = 1'b1;
                        n.pdat = {q.addr, n.sh};
                    end
                    n.addr = q.addr + 6'h01;
                    n.ob = q.mem[n.addr];
                end
            end
        end else if (fall[`RSA_I_SCK] && q.st == RSA_DATA && !q.wr) begin
            n.sdo = q.ob[7];
            n.ob = {q.ob[6:0], 1'b0};
            n.oe = 1'b1;
        end
        // ************************************************
        // Map update: writes, then counter transfer
        // ************************************************
        drain = f_valid && !tick;
        if (drain) begin
            n.mem[f_data[13:8]] = f_data[7:0];
            if (f_data[13:8] <= `RSA_LAST_CLK) begin
                n.cnt[f_data[10:8]] = f_data[7:0];
            end
        end
        frozen = q.st != RSA_IDLE && q.addr <= `RSA_LAST_CLK;
        if (!frozen) begin
            n.mem[7:0] = n.cnt;
        end
    end

    // Async reset takes constants only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '{s1: `RSA_SYNC_RST, s2: `RSA_SYNC_RST, s3: `RSA_SYNC_RST,
                   f: `RSA_SYNC_RST, st: RSA_IDLE, rec: '1, wp: 1'b1,
                   default: '0};
        end else begin
            q <= n;
        end
    end

    assign sdo_o = q.sdo;
    assign sdo_oe_o = q.oe;
    assign wr_protect_o = q.wp;

    // ************************************************
    // Checks
    // ************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    oe_release_a: assert property ($rose(q.f[`RSA_I_CS])
                                   |=> !sdo_oe_o)
        else $error("data output driven while deselected");
    start_cmd_a: assert property (cs_fall
                                  |=> q.st == RSA_CMD && q.bits == 0)
        else $error("transaction did not start");
    abort_pf_a: assert property (!q.f[`RSA_I_POK] |=> q.st == RSA_IDLE
                                 && q.addr == 6'h00)
        else $error("power fail did not abort");
    wp_hold_a: assert property ($rose(q.f[`RSA_I_POK])
                                |-> q.wp ##1 q.wp)
        else $error("protection dropped early");
    no_write_a: assert property (q.wp |=> !q.pend)
        else $error("write queued while protected");
    addr_step_a: assert property (byte_done && !n.wp
                                  |=> q.addr == $past(q.addr) + 6'h01)
        else $error("address did not advance");
    cmd_decode_a: assert property (cmd_done |=> q.addr == q.sh[5:0]
                                   && q.wr == q.sh[7])
        else $error("command byte decoded wrongly");
    msb_out_a: assert property (fall[`RSA_I_SCK] && q.st == RSA_DATA
                                && !q.wr && !n.wp && !nf[`RSA_I_CS]
                                |=> sdo_o == $past(q.ob[7]) && sdo_oe_o)
        else $error("output bit order wrong");
    shift_in_a: assert property (shift_en
                                 |=> q.sh[0] == q.f[`RSA_I_SDI])
        else $error("input bit not sampled");
    freeze_a: assert property (frozen && !drain
                               |=> q.mem[7:0] == $past(q.mem[7:0]))
        else $error("clock bytes changed while addressed");
    tick_a: assert property (tick |=> q.cnt[0] != $past(q.cnt[0]))
        else $error("time base tick lost");

    write_c: cover property (byte_done && q.wr);
    read_burst_c: cover property (byte_done && !q.wr ##[1:600] byte_done);
    wrap_c: cover property (byte_done && q.addr == 6'h3F);
    pf_mid_c: cover property (q.st == RSA_DATA ##1 !q.f[`RSA_I_POK]);
endmodule

`default_nettype wire

//--- pkg/rsa_map.svh
// Constants of the serial RTC register access block
`ifndef RSA_MAP_SVH
`define RSA_MAP_SVH
`define RSA_CLK_HZ 100_000_000
`define RSA_HZ_PER_MHZ 1_000_000
`define RSA_OSC_HZ 32768
`define RSA_HUND_HZ 100
`define RSA_REC_US 1000
`define RSA_FIFO_DEPTH 4
`define RSA_NSYNC 5
`define RSA_I_CS 0
`define RSA_I_SCK 1
`define RSA_I_SDI 2
`define RSA_I_OSC 3
`define RSA_I_POK 4
`define RSA_SYNC_RST 5'h01
`define RSA_LAST_BIT 3'h7
`define RSA_WR_BIT 7
`define RSA_LAST_CLK 6'h07
`define RSA_A_HUND 0
`define RSA_A_SEC 1
`define RSA_A_MIN 2
`define RSA_A_HOUR 3
`define RSA_A_DAY 4
`define RSA_A_DATE 5
`define RSA_A_MON 6
`define RSA_A_YEAR 7
`define RSA_MAX_99 8'h99
`define RSA_MAX_59 8'h59
`define RSA_MAX_HR 6'h23
`define RSA_MAX_DAY 3'h7
`define RSA_MAX_MON 5'h12
`define RSA_FEB 5'h02
`define RSA_FIRST 8'h01
`endif

//--- pkg/rsa_pkg.sv
// Types of the serial RTC register access block
package rsa_pkg;
    typedef enum logic [2:0] {
        RSA_IDLE = 3'b001,
        RSA_CMD = 3'b010,
        RSA_DATA = 3'b100
    } rsa_state_t;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] f;
        rsa_state_t st;
        logic [2:0] bits;
        logic [7:0] sh;
        logic [7:0] ob;
        logic wr;
        logic [5:0] addr;
        logic sdo;
        logic oe;
        logic pend;
        logic [13:0] pdat;
        logic [15:0] acc;
        logic [31:0] rec;
        logic wp;
        logic [7:0][7:0] cnt;
        logic [63:0][7:0] mem;
    } rsa_top_s_t;
endpackage

//--- verif/rsa_spi_master.sv
// Serial bus master model driving select, clock and data pins
`timescale 1ns/1ps
`default_nettype none

module rsa_spi_master (
    // Clock
    input wire logic clk_i,
    // Serial bus pins
    output logic cs_b_o,
    output logic sck_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic cpol;

    initial begin
        cpol = 1'b0;
        cs_b_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end

    // ********************
    // Pin sequencing
    // ********************
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Clock set to its idle level before select falls
    task automatic start(input logic pol);
        cpol = pol;
        sck_o = pol;
        wait_clk(8);
        cs_b_o = 1'b0;
        wait_clk(8);
    endtask

    // Half period of 80 ns, data set while the clock is low
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck_o = 1'b0;
            sdi_o = tx[i];
            wait_clk(8);
            rx[i] = sdo_i;
            sck_o = 1'b1;
            wait_clk(8);
        end
    endtask

    // Clock returned to its idle level before select rises
    task automatic stop();
        sck_o = cpol;
        wait_clk(8);
        cs_b_o = 1'b1;
        sdi_o = ~sdi_o; // Released line never keeps the last bit
        wait_clk(10);
    endtask
endmodule

`default_nettype wire

//--- verif/tb.sv
// Self-checking bench of the serial RTC register access block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rsa_pkg::*;
    // Recovery count of REC_US = 1
    localparam int REC_CYC = 100;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic osc_32k_i = 1'b0;
    logic power_ok_i = 1'b1;
    wire cs_b, sck, sdi, sdo, sdo_oe, wr_protect, sdo_pin;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] dat [8];
    logic [7:0] got [8];

    assign sdo_pin = sdo_oe ? sdo : 1'bz;

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    rsa_top #(.REC_US(1)) rsa_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .osc_32k_i(osc_32k_i), .power_ok_i(power_ok_i),
        .wr_protect_o(wr_protect)
    );

    rsa_spi_master rsa_spi_master_inst (
        .clk_i(clk_i), .cs_b_o(cs_b), .sck_o(sck), .sdi_o(sdi),
        .sdo_i(sdo_pin)
    );

    // ********************
    // Shared tasks
    // ********************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 20k cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic xfer(input logic pol, input logic [7:0] cmd, input int n);
        logic [7:0] rx;
        rsa_spi_master_inst.start(pol);
        rsa_spi_master_inst.shift(cmd, 8, rx);
        for (int i = 0; i < n; i++) begin
            rsa_spi_master_inst.shift(dat[i], 8, rx);
            got[i] = rx;
        end
        rsa_spi_master_inst.stop();
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic test_protect();
        int n;
        logic [7:0] rx;
        n = 0;
        check({7'h00, wr_protect}, 8'h01);
        while (wr_protect !== 1'b0 && n < 400) begin
            wait_clk(1);
            n++;
        end
        check(8'(n > REC_CYC && n < REC_CYC + 8), 8'h01);
        check({7'h00, sdo_pin}, 8'h0Z);
        dat[0] = 8'h11;
        xfer(1'b0, 8'hA1, 1);
        // Supply fails in mid-byte of a write to the same place
        rsa_spi_master_inst.start(1'b0);
        rsa_spi_master_inst.shift(8'hA1, 8, rx);
        rsa_spi_master_inst.shift(8'h99, 4, rx);
        power_ok_i = 1'b0;
        wait_clk(10);
        check({7'h00, wr_protect}, 8'h01);
        rsa_spi_master_inst.shift(8'h99, 4, rx);
        rsa_spi_master_inst.stop();
        dat[0] = 8'h77;
        xfer(1'b0, 8'hA1, 1);
        power_ok_i = 1'b1;
        wait_clk(REC_CYC / 2);
        check({7'h00, wr_protect}, 8'h01);
        wait_clk(REC_CYC);
        check({7'h00, wr_protect}, 8'h00);
        xfer(1'b0, 8'h21, 1);
        check(got[0], 8'h11);
    endtask

    // Burst through the top of the map, bit six set on the write only
    task automatic test_burst(input logic pol);
        logic [7:0] e [4];
        e = '{8'h12, 8'h34, 8'h56, 8'h07};
        for (int i = 0; i < 4; i++) begin
            dat[i] = e[i] ^ {8{pol}};
        end
        xfer(pol, 8'hFE, 4);
        check({7'h00, sdo_oe}, 8'h00);
        xfer(pol, 8'h3E, 4);
        for (int i = 0; i < 4; i++) begin
            check(got[i], e[i] ^ {8{pol}});
        end
    endtask

    task automatic test_partial();
        logic [7:0] rx;
        dat[0] = 8'h3C;
        xfer(1'b0, 8'hA0, 1);
        rsa_spi_master_inst.start(1'b0);
        rsa_spi_master_inst.shift(8'hA0, 8, rx);
        rsa_spi_master_inst.shift(8'hC3, 5, rx);
        rsa_spi_master_inst.stop();
        xfer(1'b0, 8'h20, 1);
        check(got[0], 8'h3C);
    endtask

    // One tick per 328 oscillator rises from the last second of a day
    task automatic test_roll();
        logic [7:0] dt [4];
        logic [7:0] mo [4];
        logic [7:0] yr [4];
        logic [7:0] ed [4];
        logic [7:0] em [4];
        logic [7:0] ey [4];
        logic [7:0] e [8];
        dt = '{8'h28, 8'h28, 8'h30, 8'h31};
        mo = '{8'h02, 8'h02, 8'h04, 8'h12};
        yr = '{8'h01, 8'h04, 8'h05, 8'h99};
        ed = '{8'h01, 8'h29, 8'h01, 8'h01};
        em = '{8'h03, 8'h02, 8'h05, 8'h01};
        ey = '{8'h01, 8'h04, 8'h05, 8'h00};
        for (int c = 0; c < 4; c++) begin
            dat = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, dt[c], mo[c], yr[c]};
            xfer(1'b0, 8'h80, 8);
            repeat (328) begin
                osc_32k_i = 1'b1;
                wait_clk(2);
                osc_32k_i = 1'b0;
                wait_clk(2);
            end
            xfer(1'b0, 8'h00, 8);
            e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, ed[c], em[c], ey[c]};
            for (int i = 0; i < 8; i++) begin
                check(got[i], e[i]);
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        test_protect();
        test_burst(1'b0);
        test_burst(1'b1);
        test_partial();
        test_roll();
        summarize();
    end
endmodule

`default_nettype wire
